// File: hdl/fpl_top.sv
/*
  Flash programming sequencer with lock protection, code array and
  AXI4-Lite control. Assumes the programmer pins are asynchronous.
*/
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module fpl_top #(
  parameter int         AW           = 13,
  parameter bit         HV_MODE      = 1'b1,
  parameter logic [7:0] MAKER_ID     = 8'h5A,  // Arbitrary value
  parameter logic [7:0] PART_ID      = 8'hC3,  // Arbitrary value
  parameter int         WRITE_CYCLES = fpl_pkg::WRITE_CYCLES,
  parameter int         ERASE_CYCLES = fpl_pkg::ERASE_CYCLES
) (
  input  logic          aclk,
  input  logic          aresetn,
  input  logic [7:0]    s_axi_awaddr,
  input  logic          s_axi_awvalid,
  output logic          s_axi_awready,
  input  logic [31:0]   s_axi_wdata,
  input  logic [3:0]    s_axi_wstrb,
  input  logic          s_axi_wvalid,
  output logic          s_axi_wready,
  output logic [1:0]    s_axi_bresp,
  output logic          s_axi_bvalid,
  input  logic          s_axi_bready,
  input  logic [7:0]    s_axi_araddr,
  input  logic          s_axi_arvalid,
  output logic          s_axi_arready,
  output logic [31:0]   s_axi_rdata,
  output logic [1:0]    s_axi_rresp,
  output logic          s_axi_rvalid,
  input  logic          s_axi_rready,
  input  logic          prog_reset_pin,
  input  logic          prog_fetch_strobe_n,
  input  logic          latch_strobe_prog_pulse,
  input  logic          ext_access_prog_supply,
  input  logic          prog_supply_hv,
  input  logic          mode_select_a,
  input  logic          mode_select_b,
  input  logic          mode_select_c,
  input  logic          mode_select_d,
  input  logic [AW-1:0] prog_addr,
  input  logic [7:0]    prog_data_in,
  output logic [7:0]    prog_data_out,
  output logic          prog_data_oe,
  output logic          ready_busy_pin,
  output logic          ext_fetch_enable
);
  localparam int PW    = 17 + AW;
  localparam int DEPTH = 1 << AW;

  typedef struct packed {
    fpl_pkg::fpl_phase_t phase;
    logic [AW-1:0]       last_addr;
    logic [7:0]          last_data;
    logic                lock_bit_one;
    logic                lock_bit_two;
    logic                lock_bit_three;
    logic                ea_latch;
    logic                strobe_q;
    logic [AW-1:0]       walk;
    logic [7:0]          dout;
    logic                doe;
    logic                rdy;
    logic                ext_ok;
    logic                ext_exec;
    logic [AW-1:0]       code_addr;
    logic                tbl_denied;
    logic                aw_ok;
    logic [7:0]          aw_addr;
    logic                w_ok;
    logic [31:0]         wdat;
    logic [3:0]          wstb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } fpl_state_t;

  fpl_state_t          s;
  fpl_state_t          next_s;
  logic [PW-1:0]       pins;
  logic                p_rst;
  logic                p_fetch_n;
  logic                p_prog;
  logic                p_ea;
  logic                p_hv;
  logic [3:0]          p_ms;
  logic [AW-1:0]       p_addr;
  logic [7:0]          p_data;
  fpl_pkg::fpl_op_t    op;
  logic                supply_ok;
  logic                rise;
  logic                fall;
  logic                go;
  logic                ea_eff;
  logic [7:0]          tbl_byte;
  logic [31:0]         status_word;
  logic                mem_we;
  logic [AW-1:0]       mem_waddr;
  logic [7:0]          mem_wdata;
  logic [31:0]         wmerge;
  logic [7:0]          mem [DEPTH];

  fpl_tmr_if tmr ();

  fpl_sync #(
    .W (PW)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({prog_reset_pin, prog_fetch_strobe_n,
               latch_strobe_prog_pulse, ext_access_prog_supply,
               prog_supply_hv, mode_select_a, mode_select_b,
               mode_select_c, mode_select_d, prog_addr, prog_data_in}),
    .q       (pins)
  );

  fpl_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tmr     (tmr.tmr)
  );

  assign {p_rst, p_fetch_n, p_prog, p_ea, p_hv, p_ms, p_addr, p_data} = pins;

  function automatic fpl_pkg::fpl_op_t fpl_decode(input logic [3:0] ms);
    case (ms)
      fpl_pkg::MS_WRITE: fpl_decode = fpl_pkg::FPL_OP_WRITE;
      fpl_pkg::MS_READ:  fpl_decode = fpl_pkg::FPL_OP_READ;
      fpl_pkg::MS_LOCK1: fpl_decode = fpl_pkg::FPL_OP_LOCK1;
      fpl_pkg::MS_LOCK2: fpl_decode = fpl_pkg::FPL_OP_LOCK2;
      fpl_pkg::MS_LOCK3: fpl_decode = fpl_pkg::FPL_OP_LOCK3;
      fpl_pkg::MS_ERASE: fpl_decode = fpl_pkg::FPL_OP_ERASE;
      fpl_pkg::MS_SIG:   fpl_decode = fpl_pkg::FPL_OP_SIG;
      default:           fpl_decode = fpl_pkg::FPL_OP_NONE;
    endcase
  endfunction

  function automatic logic [31:0] fpl_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  stb);
    logic [31:0] m;
    m = {{8{stb[3]}}, {8{stb[2]}}, {8{stb[1]}}, {8{stb[0]}}};
    fpl_merge = (old & ~m) | (wd & m);
  endfunction

  // Delivered state of the array
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = fpl_pkg::ERASED_BYTE;
    end
  end

  // Plain always: the array is also preset by the initial block
  always @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  always_comb begin
    op        = (p_rst && !p_fetch_n) ? fpl_decode(p_ms)
                                     : fpl_pkg::FPL_OP_NONE;
    supply_ok = HV_MODE ? p_hv : p_ea;
    rise      = p_prog && !s.strobe_q;
    fall      = !p_prog && s.strobe_q;
    ea_eff    = s.lock_bit_one ? s.ea_latch : p_ea;
    tbl_byte  = (s.ext_exec && s.lock_bit_one) ? fpl_pkg::BLOCKED_BYTE
                                               : mem[s.code_addr];
    // Lock bits deliberately absent
    status_word = 32'h0;
    status_word[fpl_pkg::STAT_BUSY_BIT]    = !s.rdy;
    status_word[fpl_pkg::STAT_EA_EFF_BIT]  = ea_eff;
    status_word[fpl_pkg::STAT_EA_MISM_BIT] =
      s.lock_bit_one && (s.ea_latch != p_ea);
    status_word[fpl_pkg::STAT_TBL_DEN_BIT] = s.tbl_denied;
    status_word[fpl_pkg::STAT_EXT_OK_BIT]  = s.ext_ok;
  end

  always_comb begin
    next_s          = s;
    go              = 1'b0;
    mem_we          = 1'b0;
    mem_waddr       = p_addr;
    mem_wdata       = mem[p_addr] & p_data;
    wmerge          = 32'h0;
    tmr.start       = 1'b0;
    tmr.abort       = 1'b0;
    tmr.cycles      = 32'(WRITE_CYCLES);
    next_s.strobe_q = p_prog;
    if (p_rst && s.lock_bit_one) begin
      next_s.ea_latch = p_ea;
    end
    case (s.phase)
      fpl_pkg::FPL_IDLE: begin
        if (rise && supply_ok) begin
          case (op)
            fpl_pkg::FPL_OP_WRITE: begin
              if (!s.lock_bit_one) begin
                mem_we           = 1'b1;
                next_s.last_addr = p_addr;
                next_s.last_data = p_data;
                go               = 1'b1;
              end
            end
            fpl_pkg::FPL_OP_LOCK1: begin
              next_s.lock_bit_one = 1'b1;
              go                  = 1'b1;
            end
            fpl_pkg::FPL_OP_LOCK2: begin
              next_s.lock_bit_two = 1'b1;
              go                  = 1'b1;
            end
            fpl_pkg::FPL_OP_LOCK3: begin
              next_s.lock_bit_three = 1'b1;
              go                    = 1'b1;
            end
            default: begin
              go = 1'b0;
            end
          endcase
        end else if (fall && supply_ok && op == fpl_pkg::FPL_OP_ERASE) begin
          tmr.cycles   = 32'(ERASE_CYCLES);
          tmr.start    = 1'b1;
          next_s.phase = fpl_pkg::FPL_ERASE_HOLD;
        end
        if (go) begin
          tmr.start    = 1'b1;
          next_s.phase = fpl_pkg::FPL_WRITE_BUSY;
        end
      end
      fpl_pkg::FPL_WRITE_BUSY: begin
        // New strobes are not looked at here
        if (tmr.done) begin
          next_s.phase = fpl_pkg::FPL_IDLE;
        end
      end
      fpl_pkg::FPL_ERASE_HOLD: begin
        if (p_prog || op != fpl_pkg::FPL_OP_ERASE) begin
          tmr.abort    = 1'b1;
          next_s.phase = fpl_pkg::FPL_IDLE;
        end else if (tmr.done) begin
          next_s.walk  = '0;
          next_s.phase = fpl_pkg::FPL_ERASE_WALK;
        end
      end
      fpl_pkg::FPL_ERASE_WALK: begin
        mem_we      = 1'b1;
        mem_waddr   = s.walk;
        mem_wdata   = fpl_pkg::ERASED_BYTE;
        next_s.walk = s.walk + AW'(1);
        if (&s.walk) begin
          next_s.lock_bit_one   = 1'b0;
          next_s.lock_bit_two   = 1'b0;
          next_s.lock_bit_three = 1'b0;
          next_s.phase          = fpl_pkg::FPL_IDLE;
        end
      end
      default: begin
        next_s.phase = fpl_pkg::FPL_IDLE;
      end
    endcase
    next_s.rdy = (next_s.phase == fpl_pkg::FPL_IDLE);

    // Programmer read path
    next_s.doe  = 1'b0;
    next_s.dout = fpl_pkg::ERASED_BYTE;
    if (op == fpl_pkg::FPL_OP_READ && !s.lock_bit_two) begin
      next_s.doe  = 1'b1;
      next_s.dout = mem[p_addr];
      // Follows the next phase so that true data comes with ready
      if (next_s.phase == fpl_pkg::FPL_WRITE_BUSY &&
          p_addr == next_s.last_addr) begin
        next_s.dout[7] = ~next_s.last_data[7];
      end
    end else if (op == fpl_pkg::FPL_OP_SIG) begin
      next_s.doe = 1'b1;
      if (p_addr == AW'(fpl_pkg::SIG_ADDR_MAKER)) begin
        next_s.dout = MAKER_ID;
      end else if (p_addr == AW'(fpl_pkg::SIG_ADDR_PART)) begin
        next_s.dout = PART_ID;
      end else if (p_addr == AW'(fpl_pkg::SIG_ADDR_VPP)) begin
        next_s.dout = HV_MODE ? fpl_pkg::SIG_VPP_HV : fpl_pkg::SIG_VPP_LV;
      end
    end
    next_s.ext_ok = !ea_eff && !s.lock_bit_three;

    // Register write channel
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_ok   = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_ok = 1'b1;
      next_s.wdat = s_axi_wdata;
      next_s.wstb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_ok && s.w_ok) begin
      next_s.aw_ok  = 1'b0;
      next_s.w_ok   = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = fpl_pkg::RESP_OKAY;
      case (s.aw_addr)
        fpl_pkg::REG_CTRL: begin
          wmerge          = fpl_merge(32'(s.ext_exec), s.wdat, s.wstb);
          next_s.ext_exec = wmerge[fpl_pkg::CTRL_EXT_EXEC_BIT];
        end
        fpl_pkg::REG_CODE_ADDR: begin
          wmerge           = fpl_merge(32'(s.code_addr), s.wdat, s.wstb);
          next_s.code_addr = wmerge[AW-1:0];
        end
        fpl_pkg::REG_CODE_DATA, fpl_pkg::REG_STATUS: begin
          next_s.bresp = fpl_pkg::RESP_OKAY;
        end
        default: begin
          next_s.bresp = fpl_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Register read channel
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = fpl_pkg::RESP_OKAY;
      next_s.rdata  = 32'h0;
      case (s_axi_araddr)
        fpl_pkg::REG_CTRL:      next_s.rdata = 32'(s.ext_exec);
        fpl_pkg::REG_CODE_ADDR: next_s.rdata = 32'(s.code_addr);
        fpl_pkg::REG_CODE_DATA: begin
          next_s.rdata      = 32'(tbl_byte);
          next_s.tbl_denied = s.ext_exec && s.lock_bit_one;
        end
        fpl_pkg::REG_STATUS:    next_s.rdata = status_word;
        default:                next_s.rresp = fpl_pkg::RESP_SLVERR;
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.rdy      <= 1'b1;
      s.strobe_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready    = !s.aw_ok && !s.bvalid;
  assign s_axi_wready     = !s.w_ok && !s.bvalid;
  assign s_axi_bvalid     = s.bvalid;
  assign s_axi_bresp      = s.bresp;
  assign s_axi_arready    = !s.rvalid;
  assign s_axi_rvalid     = s.rvalid;
  assign s_axi_rdata      = s.rdata;
  assign s_axi_rresp      = s.rresp;
  assign prog_data_out    = s.dout;
  assign prog_data_oe     = s.doe;
  assign ready_busy_pin   = s.rdy;
  assign ext_fetch_enable = s.ext_ok;

  default clocking fpl_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_write_lock_gate: assert property (
    mem_we |-> s.phase == fpl_pkg::FPL_ERASE_WALK || !s.lock_bit_one)
    else $error("Array written while lock one set");
  chk_supply_gate: assert property (
    mem_we && s.phase == fpl_pkg::FPL_IDLE |-> supply_ok)
    else $error("Array written without matching supply");
  chk_verify_blocked: assert property (
    s.lock_bit_two && op == fpl_pkg::FPL_OP_READ |=> !prog_data_oe)
    else $error("Verify data driven while locked");
  chk_ext_exec_block: assert property (
    s.lock_bit_three |=> !ext_fetch_enable)
    else $error("External fetch allowed with lock three");
  chk_busy_after_strobe: assert property (
    s.phase == fpl_pkg::FPL_IDLE && rise && supply_ok &&
    op == fpl_pkg::FPL_OP_LOCK1 |=> !ready_busy_pin [*2])
    else $error("Ready/busy not low after strobe");
  chk_poll_invert: assert property (
    next_s.phase == fpl_pkg::FPL_WRITE_BUSY &&
    op == fpl_pkg::FPL_OP_READ &&
    !s.lock_bit_two && p_addr == next_s.last_addr
    |=> prog_data_oe && prog_data_out[7] != $past(next_s.last_data[7]))
    else $error("Polling bit not inverted during write");
  chk_ready_return: assert property (
    s.phase == fpl_pkg::FPL_WRITE_BUSY && tmr.done
    |=> ready_busy_pin && s.phase == fpl_pkg::FPL_IDLE)
    else $error("Not ready after write cycle");
  chk_busy_ignores: assert property (
    s.phase == fpl_pkg::FPL_WRITE_BUSY |-> !mem_we && !tmr.start)
    else $error("Strobe accepted during write cycle");
  chk_erase_fill: assert property (
    s.phase == fpl_pkg::FPL_ERASE_WALK
    |-> mem_we && mem_wdata == fpl_pkg::ERASED_BYTE)
    else $error("Erase walk not writing ones");
  chk_ea_latch: assert property (
    p_rst && s.lock_bit_one |=> s.ea_latch == $past(p_ea))
    else $error("Access level not latched");
  chk_sig_vpp: assert property (
    op == fpl_pkg::FPL_OP_SIG && p_addr == AW'(fpl_pkg::SIG_ADDR_VPP)
    |=> prog_data_out == (HV_MODE ? fpl_pkg::SIG_VPP_HV
                                  : fpl_pkg::SIG_VPP_LV))
    else $error("Wrong supply mode signature");
endmodule

// File: hdl/fpl_pkg.sv
/*
  Shared constants and types of the flash programming and lock block.
  Assumes one 250 MHz clock and an AXI4-Lite register bus.
*/
package fpl_pkg;

  // Timing
  localparam real CLK_PERIOD_NS = 4.0;
  localparam real WRITE_TIME_MS = 1.5;
  localparam real ERASE_TIME_MS = 10.0;
  localparam int  WRITE_CYCLES  =
    int'($floor(WRITE_TIME_MS * 1.0E6 / CLK_PERIOD_NS));
  localparam int  ERASE_CYCLES  =
    int'($ceil(ERASE_TIME_MS * 1.0E6 / CLK_PERIOD_NS));

  // Register offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_CODE_ADDR = 8'h04;
  localparam logic [7:0] REG_CODE_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0C;

  // Field positions
  localparam int CTRL_EXT_EXEC_BIT = 0;
  localparam int STAT_BUSY_BIT     = 0;
  localparam int STAT_EA_EFF_BIT   = 1;
  localparam int STAT_EA_MISM_BIT  = 2;
  localparam int STAT_TBL_DEN_BIT  = 3;
  localparam int STAT_EXT_OK_BIT   = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Array and signature values
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;
  localparam logic [7:0] BLOCKED_BYTE   = 8'h00;
  localparam logic [7:0] SIG_ADDR_MAKER = 8'h30;
  localparam logic [7:0] SIG_ADDR_PART  = 8'h31;
  localparam logic [7:0] SIG_ADDR_VPP   = 8'h32;
  localparam logic [7:0] SIG_VPP_HV     = 8'hFF;
  localparam logic [7:0] SIG_VPP_LV     = 8'h05;

  // Mode select patterns, ordered {a, b, c, d}
  localparam logic [3:0] MS_WRITE = 4'h7;
  localparam logic [3:0] MS_READ  = 4'h3;
  localparam logic [3:0] MS_LOCK1 = 4'hF;
  localparam logic [3:0] MS_LOCK2 = 4'hC;
  localparam logic [3:0] MS_LOCK3 = 4'hA;
  localparam logic [3:0] MS_ERASE = 4'h8;
  localparam logic [3:0] MS_SIG   = 4'h0;

  typedef enum logic [2:0] {
    FPL_OP_NONE  = 3'b000,
    FPL_OP_WRITE = 3'b001,
    FPL_OP_READ  = 3'b010,
    FPL_OP_LOCK1 = 3'b011,
    FPL_OP_LOCK2 = 3'b100,
    FPL_OP_LOCK3 = 3'b101,
    FPL_OP_ERASE = 3'b110,
    FPL_OP_SIG   = 3'b111
  } fpl_op_t;

  typedef enum logic [1:0] {
    FPL_IDLE       = 2'b00,
    FPL_WRITE_BUSY = 2'b01,
    FPL_ERASE_HOLD = 2'b10,
    FPL_ERASE_WALK = 2'b11
  } fpl_phase_t;

endpackage

// File: hdl/fpl_tmr_if.sv
/*
  Start, abort and completion signals between sequencer and cycle timer.
  Assumes both ends share aclk.
*/
`timescale 1ns/10ps
interface fpl_tmr_if;
  logic        start;
  logic        abort;
  logic [31:0] cycles;
  logic        busy;
  logic        done;
  modport ctl (output start, abort, cycles, input busy, done);
  modport tmr (input start, abort, cycles, output busy, done);
endinterface

// File: hdl/fpl_sync.sv
/*
  Three-stage pin synchroniser; a bit changes once stages two and three
  agree. Assumes inputs asynchronous to aclk.
*/
`timescale 1ns/10ps
module fpl_sync #(
  parameter int W = 1
) (
  input  logic         aclk,
  input  logic         aresetn,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } fpl_sync_state_t;

  fpl_sync_state_t s;
  fpl_sync_state_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = d;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.q  = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.q);
  end

  // Idle pin levels are high: no programming mode, strobe released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule

// File: hdl/fpl_timer.sv
/*
  Down-counter that signals done a set number of cycles after start.
  Assumes start is ignored while busy.
*/
`timescale 1ns/10ps
module fpl_timer (
  input logic      aclk,
  input logic      aresetn,
  fpl_tmr_if.tmr   tmr
);
  typedef struct packed {
    logic [31:0] count;
    logic        busy;
    logic        done;
  } fpl_tmr_state_t;

  fpl_tmr_state_t s;
  fpl_tmr_state_t next_s;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (tmr.abort) begin
      next_s.busy = 1'b0;
    end else if (tmr.start && !s.busy) begin
      next_s.busy  = 1'b1;
      next_s.count = (tmr.cycles > 32'h1) ? tmr.cycles - 32'h1 : 32'h0;
    end else if (s.busy) begin
      if (s.count == 32'h0) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.count = s.count - 32'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tmr.busy = s.busy;
  assign tmr.done = s.done;
endmodule

// File: testbench/fpl_prog_model.sv
/*
  Behavioural external programmer driving the flash programming pins.
  Assumes the bench clock and a 6-bit array address.
*/
`timescale 1ns/10ps
module fpl_prog_model (
  input  logic       aclk,
  output logic       prog_reset_pin,
  output logic       prog_fetch_strobe_n,
  output logic       latch_strobe_prog_pulse,
  output logic       ext_access_prog_supply,
  output logic       prog_supply_hv,
  output logic       mode_select_a,
  output logic       mode_select_b,
  output logic       mode_select_c,
  output logic       mode_select_d,
  output logic [5:0] prog_addr,
  output logic [7:0] prog_data_in
);
  initial begin
    prog_reset_pin = 1'b1;
    prog_fetch_strobe_n = 1'b0;
    latch_strobe_prog_pulse = 1'b1;
    ext_access_prog_supply = 1'b1;
    prog_supply_hv = 1'b0;
    {mode_select_a, mode_select_b, mode_select_c, mode_select_d} = 4'h3;
    prog_addr = 6'h00;
    prog_data_in = 8'h00;
  end

  // Address, data, pattern, supply, a cycle apart, then settle
  task automatic setp(input logic [3:0] ms, input logic [5:0] a,
                      input logic [7:0] d, input logic hv, input logic ea);
    prog_addr <= a;
    @(posedge aclk);
    // Data line not in use shows the inverse of its last value
    prog_data_in <= (ms == fpl_pkg::MS_WRITE) ? d : ~prog_data_in;
    @(posedge aclk);
    {mode_select_a, mode_select_b, mode_select_c, mode_select_d} <= ms;
    @(posedge aclk);
    prog_supply_hv <= hv;
    ext_access_prog_supply <= ea;
    repeat (8) @(posedge aclk);
  endtask

  task automatic pulse(input int lo);
    latch_strobe_prog_pulse <= 1'b0;
    repeat (lo) @(posedge aclk);
    latch_strobe_prog_pulse <= 1'b1;
    @(posedge aclk);
  endtask
endmodule

// File: testbench/test_flash_program_lock_interface.sv
/*
  Self-checking bench of the flash programming and lock block.
  Assumes the programmer model and shortened write and erase counts.
*/
`timescale 1ns/10ps
module test_flash_program_lock_interface;
  localparam int WC = 40;
  localparam int EC = 30;
  localparam logic [7:0] MK = 8'h5A;  // Arbitrary value
  localparam logic [7:0] PT = 8'hC3;  // Arbitrary value
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        prog_reset_pin, prog_fetch_strobe_n, latch_strobe_prog_pulse;
  logic        ext_access_prog_supply, prog_supply_hv;
  logic        mode_select_a, mode_select_b, mode_select_c, mode_select_d;
  logic [5:0]  prog_addr;
  logic [7:0]  prog_data_in, prog_data_out;
  logic        prog_data_oe, ready_busy_pin, ext_fetch_enable;
  int          fail_count, samples_checked;

  fpl_top #(.AW(6), .MAKER_ID(MK), .PART_ID(PT), .WRITE_CYCLES(WC),
    .ERASE_CYCLES(EC)) i_dut (.*);
  fpl_prog_model i_prog (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // One register access; holds each channel until it is taken
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    logic aw, w, ar, b, r;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    forever begin
      #1;
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      b = s_axi_bvalid && s_axi_bready;
      r = s_axi_rvalid && s_axi_rready;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      if (b || r) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask

  task automatic wait_rdy();
    for (int n = 0; n < 200 && ready_busy_pin !== 1'b1; n++) @(posedge aclk);
  endtask

  task automatic rdp(input logic [3:0] ms, input logic [5:0] a);
    i_prog.setp(ms, a, 8'h00, 1'b0, ext_access_prog_supply);
  endtask

  task automatic prog(input logic [3:0] ms, input logic [7:0] d);
    i_prog.setp(ms, 6'h03, d, 1'b1, ext_access_prog_supply);
    i_prog.pulse(6);
    repeat (8) @(posedge aclk);
    wait_rdy();
  endtask

  task automatic t_write();
    rdp(fpl_pkg::MS_READ, 6'h03);
    chk(prog_data_out, fpl_pkg::ERASED_BYTE);
    chk(prog_data_oe, 1'b1);
    bus(1'b0, 8'h10, 32'h0);
    chk(rsp, fpl_pkg::RESP_SLVERR);
    i_prog.setp(fpl_pkg::MS_WRITE, 6'h03, 8'hA5, 1'b1, 1'b1);
    i_prog.pulse(6);
    i_prog.setp(fpl_pkg::MS_WRITE, 6'h03, 8'h0F, 1'b1, 1'b1);
    i_prog.pulse(6);
    rdp(fpl_pkg::MS_READ, 6'h03);
    chk(ready_busy_pin, 1'b0);
    chk(prog_data_out, 8'h25);
    wait_rdy();
    chk(ready_busy_pin, 1'b1);
    chk(prog_data_out, 8'hA5);
    bus(1'b1, fpl_pkg::REG_CODE_ADDR, 32'h3);
    chk(rsp, fpl_pkg::RESP_OKAY);
    bus(1'b0, fpl_pkg::REG_CODE_DATA, 32'h0);
    chk(rd[7:0], 8'hA5);
    for (int i = 0; i < 3; i++) begin
      rdp(fpl_pkg::MS_SIG, 6'h30 + 6'(i));
      chk(prog_data_out, i == 0 ? MK : i == 1 ? PT : 8'hFF);
    end
    $display("test write and signature done");
  endtask

  task automatic t_lock();
    prog(fpl_pkg::MS_LOCK1, 8'h00);
    i_prog.setp(fpl_pkg::MS_WRITE, 6'h04, 8'h00, 1'b1, 1'b1);
    i_prog.pulse(6);
    repeat (12) @(posedge aclk);
    chk(ready_busy_pin, 1'b1);
    rdp(fpl_pkg::MS_READ, 6'h04);
    chk(prog_data_out, 8'hFF);
    chk(prog_data_oe, 1'b1);
    bus(1'b1, fpl_pkg::REG_CTRL, 32'h1);
    bus(1'b0, fpl_pkg::REG_CODE_DATA, 32'h0);
    chk(rd[7:0], fpl_pkg::BLOCKED_BYTE);
    bus(1'b0, fpl_pkg::REG_STATUS, 32'h0);
    chk(rd[fpl_pkg::STAT_TBL_DEN_BIT], 1'b1);
    i_prog.setp(fpl_pkg::MS_READ, 6'h03, 8'h00, 1'b0, 1'b0);
    chk(ext_fetch_enable, 1'b1);
    prog(fpl_pkg::MS_LOCK2, 8'h00);
    rdp(fpl_pkg::MS_READ, 6'h03);
    chk(prog_data_oe, 1'b0);
    prog(fpl_pkg::MS_LOCK3, 8'h00);
    chk(ext_fetch_enable, 1'b0);
    $display("test lock done");
  endtask

  task automatic t_erase();
    i_prog.setp(fpl_pkg::MS_ERASE, 6'h00, 8'h00, 1'b1, 1'b1);
    i_prog.pulse(EC + 10);
    repeat (100) @(posedge aclk);
    wait_rdy();
    rdp(fpl_pkg::MS_READ, 6'h03);
    chk(prog_data_oe, 1'b1);
    chk(prog_data_out, fpl_pkg::ERASED_BYTE);
    prog(fpl_pkg::MS_WRITE, 8'h5A);
    rdp(fpl_pkg::MS_READ, 6'h03);
    chk(prog_data_out, 8'h5A);
    $display("test erase done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    fail_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_write();
    t_lock();
    t_erase();
    end_sim();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule
